/* File: hdl/rfd_cfg_mem.sv */
`timescale 1ns/1ps
`include "rfd_consts.svh"

module rfd_cfg_mem #(
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input logic clk,
    input logic rst,
    input logic we,
    input logic [AW-1:0] waddr,
    input logic [31:0] wdata,
    input logic [AW-1:0] ra_addr,
    output logic [31:0] ra_data,
    input logic [AW-1:0] rb_addr,
    output logic [31:0] rb_data
);
    typedef struct packed {
        logic [DEPTH-1:0][31:0] mem;
        logic [31:0] ra;
        logic [31:0] rb;
    } rfd_mem_regs_t;

    rfd_mem_regs_t r_q, r_d;

    always_comb begin
        r_d = r_q;
        r_d.ra = r_q.mem[ra_addr];
        r_d.rb = r_q.mem[rb_addr];
        if (we) begin
            r_d.mem[waddr] = wdata;
        end
        if (rst) begin
            r_d.mem = {DEPTH{`RFD_A_RESET}};
            r_d.ra = 32'h0;
            r_d.rb = 32'h0;
        end
    end

    always_ff @(posedge clk) begin
        r_q <= r_d;
    end

    assign ra_data = r_q.ra;
    assign rb_data = r_q.rb;
endmodule

/* File: hdl/rfd_consts.svh */
`ifndef RFD_CONSTS_SVH
`define RFD_CONSTS_SVH

// Flow configuration word, field positions
`define RFD_A_ERRH_BIT 28
`define RFD_A_FMT_HI 27
`define RFD_A_FMT_LO 26
`define RFD_A_PSLOC_BIT 25
`define RFD_A_SKIP_HI 24
`define RFD_A_SKIP_LO 16
`define RFD_A_QMGR_HI 13
`define RFD_A_QMGR_LO 12
`define RFD_A_QNUM_HI 11
`define RFD_A_QNUM_LO 0
`define RFD_A_WMASK 32'h1fff3fff
`define RFD_A_RESET 32'h00000000

// Register map, byte addresses
`define RFD_FLOW_SHIFT 5
`define RFD_FLOW_LIMIT 12'h800
`define RFD_TIMEOUT_OFS 12'h800
`define RFD_STATUS_OFS 12'h804
`define RFD_TIMEOUT_RESET 16'h0040

// Descriptor formats and layout
`define RFD_FMT_HOST 2'h0
`define RFD_FMT_MONO 2'h2
`define RFD_MONO_HDR_BYTES 32'h0000000c
`define RFD_HOST_PD_BYTES 32'h00000020

// Bus answers
`define RFD_RESP_OKAY 2'h0
`define RFD_RESP_DECERR 2'h3

`endif

/* File: hdl/rfd_flow_setup.sv */
// Functional notes
// [R1] Starvation policy bit 28 matters only on descriptor or buffer starvation.
// [R2] Policy 0: drop the packet, reclaim taken descriptors and buffers.
// [R3] Policy 1: keep the packet, retry descriptor allocation later.
// [R4] Policy 1: save state on starvation, do not advance receive FIFO.
// [R5] Policy 1: restart the suspended transfer after the timeout setting.
// [R6] Format bits 27-26: 0 host, 2 monolithic, 1 and 3 reserved.
// [R7] Placement bit 25 at 0: clear descriptor flag, words after descriptor.
// [R8] Placement bit 25 at 1: set descriptor flag, words at buffer start.
// [R9] Words in buffer: round pointer plus skip up to 32-bit boundary.
// [R10] Software keeps pointer plus skip 32-bit aligned when words in buffer.
// [R11] Host packets skip bits 24-16 bytes before words or payload.
// [R12] Payload follows the last protocol word with no gap.
// [R13] Monolithic skip covers 12-byte header, max words, 20 more for ext.
// [R14] Start skip programmed only from 0 to 511.
// [R15] Bits 15-14 read zero and ignore writes.
// [R16] Bits 13-12 name the default target manager.
// [R17] Bits 11-0 name the default target queue.
// [R18] Software changes flow setup only with all its channels disabled.
//
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "rfd_consts.svh"

module rfd_flow_setup #(
    parameter int NUM_FLOWS = 32
) (
    input logic CORE_CLK,
    input logic SYS_RST,
    input logic [11:0] AVS_ADDRESS,
    input logic AVS_READ,
    input logic AVS_WRITE,
    input logic [31:0] AVS_WRITEDATA,
    input logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic [1:0] AVS_RESPONSE,
    output logic AVS_WAITREQUEST,
    input logic PKT_REQ_VALID,
    input rfd_pkg::rfd_pkt_req_t PKT_REQ,
    output logic PKT_REQ_READY,
    output logic ALLOC_REQ,
    input logic ALLOC_GRANT,
    input logic ALLOC_STARVED,
    output logic SETUP_VALID,
    output rfd_pkg::rfd_setup_t SETUP,
    output logic DROP_PKT,
    output logic RECLAIM,
    output logic STATE_SAVE,
    output logic RETRY_START,
    output logic FIFO_ADVANCE
);
    localparam int AW = (NUM_FLOWS > 1) ? $clog2(NUM_FLOWS) : 1;

    typedef struct packed {
        logic bphase;
        logic ack;
        logic [31:0] rdata;
        logic [1:0] resp;
        logic [15:0] timeout;
        rfd_pkg::rfd_state_t st;
        rfd_pkg::rfd_pkt_req_t req;
        rfd_pkg::rfd_flow_cfg_t cfg;
        rfd_pkg::rfd_setup_t setup;
        logic setup_vld;
        logic drop;
        logic reclaim;
        logic save;
        logic retry;
        logic adv;
        logic alloc;
        logic [15:0] wait_cnt;
        logic [7:0] drop_cnt;
        logic [7:0] retry_cnt;
        logic [7:0] fmt_err_cnt;
    } rfd_regs_t;

    rfd_regs_t r_q, r_d;

    logic mem_we;
    logic [31:0] mem_wdata;
    logic [31:0] ra_data;
    logic [31:0] rb_data;
    logic [AW-1:0] ra_addr;
    logic [AW-1:0] rb_addr;
    logic [31:0] be_mask;
    logic bus_req;
    logic flow_hit;

    function automatic logic [31:0] round_up4(input logic [31:0] a);
        logic [31:0] s;
        s = a + 32'h00000003;
        return {s[31:2], 2'b00};
    endfunction

    function automatic rfd_pkg::rfd_flow_cfg_t decode_cfg(
        input logic [31:0] w
    );
        rfd_pkg::rfd_flow_cfg_t c;
        c.errh_retry = w[`RFD_A_ERRH_BIT];
        c.fmt = w[`RFD_A_FMT_HI:`RFD_A_FMT_LO];
        c.ps_in_buf = w[`RFD_A_PSLOC_BIT];
        c.skip = w[`RFD_A_SKIP_HI:`RFD_A_SKIP_LO];
        c.qmgr = w[`RFD_A_QMGR_HI:`RFD_A_QMGR_LO];
        c.qnum = w[`RFD_A_QNUM_HI:`RFD_A_QNUM_LO];
        return c;
    endfunction

    function automatic logic fmt_valid(input logic [1:0] f);
        return (f == `RFD_FMT_HOST) || (f == `RFD_FMT_MONO);
    endfunction

    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        return (v == 8'hff) ? v : v + 8'h01;
    endfunction

    // Bus side decode
    assign bus_req = AVS_READ | AVS_WRITE;
    assign flow_hit = (AVS_ADDRESS < `RFD_FLOW_LIMIT)
        && (AVS_ADDRESS[`RFD_FLOW_SHIFT-1:0] == 5'h00)
        && (32'(AVS_ADDRESS[10:`RFD_FLOW_SHIFT]) < 32'(NUM_FLOWS));
    assign ra_addr = AVS_ADDRESS[`RFD_FLOW_SHIFT +: AW];
    assign rb_addr = r_q.req.flow[AW-1:0];
    assign be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                      {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
    // Reserved bits never stored, so they read back zero  see [R15]
    assign mem_wdata = ((ra_data & ~be_mask) | (AVS_WRITEDATA & be_mask))
        & `RFD_A_WMASK;
    assign mem_we = r_q.ack & AVS_WRITE & flow_hit;

    rfd_cfg_mem #(
        .DEPTH(NUM_FLOWS),
        .AW(AW)
    ) u_cfg_mem (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .we(mem_we),
        .waddr(ra_addr),
        .wdata(mem_wdata),
        .ra_addr(ra_addr),
        .ra_data(ra_data),
        .rb_addr(rb_addr),
        .rb_data(rb_data)
    );

    always_comb begin
        rfd_pkg::rfd_flow_cfg_t c;
        logic [31:0] skip32;
        logic [31:0] tgt;
        c = decode_cfg(rb_data);
        skip32 = {23'h0, c.skip};
        tgt = 32'h0;
        r_d = r_q;
        r_d.setup_vld = 1'b0;
        r_d.drop = 1'b0;
        r_d.reclaim = 1'b0;
        r_d.save = 1'b0;
        r_d.retry = 1'b0;
        r_d.adv = 1'b0;

        // Register bus: request, lookup, answer
        if (r_q.ack) begin
            r_d.ack = 1'b0;
            r_d.bphase = 1'b0;
            if (AVS_WRITE && AVS_ADDRESS == `RFD_TIMEOUT_OFS) begin
                r_d.timeout[7:0] = AVS_BYTEENABLE[0]
                    ? AVS_WRITEDATA[7:0] : r_q.timeout[7:0];
                r_d.timeout[15:8] = AVS_BYTEENABLE[1]
                    ? AVS_WRITEDATA[15:8] : r_q.timeout[15:8];
            end
        end else if (r_q.bphase) begin
            r_d.ack = 1'b1;
            r_d.resp = `RFD_RESP_OKAY;
            if (flow_hit) begin
                r_d.rdata = AVS_READ ? (ra_data & `RFD_A_WMASK) : 32'h0;
            end else if (AVS_ADDRESS == `RFD_TIMEOUT_OFS) begin
                r_d.rdata = AVS_READ ? {16'h0, r_q.timeout} : 32'h0;
            end else if (AVS_ADDRESS == `RFD_STATUS_OFS) begin
                r_d.rdata = AVS_READ ? {r_q.retry_cnt, r_q.drop_cnt,
                    r_q.fmt_err_cnt, 5'h00,
                    (r_q.st == rfd_pkg::ST_ALLOC),
                    (r_q.st == rfd_pkg::ST_WAIT),
                    (r_q.st != rfd_pkg::ST_IDLE)} : 32'h0;
            end else begin
                r_d.rdata = 32'h0;
                r_d.resp = `RFD_RESP_DECERR;
            end
        end else if (bus_req) begin
            r_d.bphase = 1'b1;
        end

        // Per-packet setup engine
        case (r_q.st)
            rfd_pkg::ST_IDLE: begin
                if (PKT_REQ_VALID) begin
                    r_d.req = PKT_REQ;
                    r_d.st = rfd_pkg::ST_LOOKUP;
                end
            end
            rfd_pkg::ST_LOOKUP: begin
                r_d.st = rfd_pkg::ST_CALC;
            end
            rfd_pkg::ST_CALC: begin
                r_d.cfg = c;
                if (!fmt_valid(c.fmt)
                    || 32'(r_q.req.flow) >= 32'(NUM_FLOWS)) begin
                    // Reserved format or flow at or past NUM_FLOWS: packet cannot be placed  see [R6]
                    r_d.drop = 1'b1;
                    r_d.adv = 1'b1;
                    r_d.fmt_err_cnt = sat_inc(r_q.fmt_err_cnt);
                    r_d.st = rfd_pkg::ST_IDLE;
                end else begin
                    r_d.setup.fmt = c.fmt; // see [R6]
                    r_d.setup.qmgr = c.qmgr; // see [R16]
                    r_d.setup.qnum = c.qnum; // see [R17]
                    if (c.fmt == `RFD_FMT_MONO) begin
                        // Skip counts from the descriptor address
                        r_d.setup.ps_loc_flag = 1'b0;
                        r_d.setup.ps_addr = r_q.req.desc_addr
                            + `RFD_MONO_HDR_BYTES;
                        r_d.setup.payload_addr = r_q.req.desc_addr + skip32;
                    end else if (c.ps_in_buf) begin
                        tgt = round_up4(r_q.req.buf_ptr + skip32); // see [R9]
                        r_d.setup.ps_loc_flag = 1'b1; // see [R8]
                        r_d.setup.ps_addr = tgt; // see [R8] [R11]
                        // Payload packed right after the words  see [R12]
                        r_d.setup.payload_addr = tgt
                            + {22'h0, r_q.req.ps_words, 2'b00};
                    end else begin
                        r_d.setup.ps_loc_flag = 1'b0; // see [R7]
                        r_d.setup.ps_addr = r_q.req.desc_addr
                            + `RFD_HOST_PD_BYTES; // see [R7]
                        r_d.setup.payload_addr = r_q.req.buf_ptr
                            + skip32; // see [R11]
                    end
                    r_d.alloc = 1'b1;
                    r_d.st = rfd_pkg::ST_ALLOC;
                end
            end
            rfd_pkg::ST_ALLOC: begin
                if (ALLOC_GRANT) begin
                    r_d.alloc = 1'b0;
                    r_d.setup_vld = 1'b1;
                    r_d.adv = 1'b1;
                    r_d.st = rfd_pkg::ST_IDLE;
                end else if (ALLOC_STARVED) begin
                    // Policy consulted only here  see [R1]
                    r_d.alloc = 1'b0;
                    if (r_q.cfg.errh_retry) begin
                        r_d.save = 1'b1; // see [R3] [R4]
                        r_d.wait_cnt = (r_q.timeout == 16'h0)
                            ? 16'h0001 : r_q.timeout; // see [R5]
                        r_d.st = rfd_pkg::ST_WAIT;
                    end else begin
                        r_d.drop = 1'b1; // see [R2]
                        r_d.reclaim = 1'b1; // see [R2]
                        r_d.adv = 1'b1;
                        r_d.drop_cnt = sat_inc(r_q.drop_cnt);
                        r_d.st = rfd_pkg::ST_IDLE;
                    end
                end
            end
            rfd_pkg::ST_WAIT: begin
                // FIFO held, retry after the programmed delay  see [R5]
                if (r_q.wait_cnt <= 16'h0001) begin
                    r_d.wait_cnt = 16'h0;
                    r_d.retry = 1'b1; // see [R3]
                    r_d.retry_cnt = sat_inc(r_q.retry_cnt);
                    r_d.alloc = 1'b1;
                    r_d.st = rfd_pkg::ST_ALLOC;
                end else begin
                    r_d.wait_cnt = r_q.wait_cnt - 16'h0001;
                end
            end
            default: begin
                r_d.st = rfd_pkg::ST_IDLE;
            end
        endcase

        if (SYS_RST) begin
            r_d = '0;
            r_d.timeout = `RFD_TIMEOUT_RESET;
            r_d.st = rfd_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        r_q <= r_d;
    end

    assign AVS_WAITREQUEST = bus_req & ~r_q.ack;
    assign AVS_READDATA = r_q.rdata;
    assign AVS_RESPONSE = r_q.resp;
    assign PKT_REQ_READY = (r_q.st == rfd_pkg::ST_IDLE) & ~SYS_RST;
    assign ALLOC_REQ = r_q.alloc;
    assign SETUP_VALID = r_q.setup_vld;
    assign SETUP = r_q.setup;
    assign DROP_PKT = r_q.drop;
    assign RECLAIM = r_q.reclaim;
    assign STATE_SAVE = r_q.save;
    assign RETRY_START = r_q.retry;
    assign FIFO_ADVANCE = r_q.adv;
endmodule

/* File: hdl/rfd_pkg.sv */
package rfd_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOOKUP,
        ST_CALC,
        ST_ALLOC,
        ST_WAIT
    } rfd_state_t;

    typedef struct packed {
        logic errh_retry;
        logic [1:0] fmt;
        logic ps_in_buf;
        logic [8:0] skip;
        logic [1:0] qmgr;
        logic [11:0] qnum;
    } rfd_flow_cfg_t;

    typedef struct packed {
        logic [7:0] flow;
        logic [31:0] desc_addr;
        logic [31:0] buf_ptr;
        logic [7:0] ps_words;
    } rfd_pkt_req_t;

    typedef struct packed {
        logic [1:0] fmt;
        logic ps_loc_flag;
        logic [31:0] ps_addr;
        logic [31:0] payload_addr;
        logic [1:0] qmgr;
        logic [11:0] qnum;
    } rfd_setup_t;

endpackage

/* File: verif/rfd_alloc_model.sv */
`timescale 1ns/1ps
module rfd_alloc_model (
    input logic clk,
    input logic rst,
    input logic alloc_req,
    input logic starve,
    input logic [3:0] delay,
    output logic grant,
    output logic starved
);
    logic [3:0] cnt_q;
    // One answer per request, after delay cycles
    always_ff @(posedge clk) begin
        grant <= 1'b0;
        starved <= 1'b0;
        cnt_q <= 4'h0;
        if (!rst && alloc_req && !grant && !starved) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == delay) begin
                grant <= !starve;
                starved <= starve;
            end
        end
    end
endmodule

/* File: verif/rfd_flow_setup_monitor.sv */
`timescale 1ns/1ps
module rfd_flow_setup_monitor (
    input logic CORE_CLK,
    input logic SYS_RST,
    input logic [11:0] AVS_ADDRESS,
    input logic AVS_READ,
    input logic [31:0] AVS_READDATA,
    input logic AVS_WAITREQUEST,
    input logic PKT_REQ_VALID,
    input logic PKT_REQ_READY,
    input logic ALLOC_REQ,
    input logic ALLOC_GRANT,
    input logic ALLOC_STARVED,
    input logic SETUP_VALID,
    input rfd_pkg::rfd_setup_t SETUP,
    input logic DROP_PKT,
    input logic RECLAIM,
    input logic STATE_SAVE,
    input logic RETRY_START,
    input logic FIFO_ADVANCE
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    property p_grant;
        ALLOC_REQ && ALLOC_GRANT |=> SETUP_VALID && FIFO_ADVANCE && !STATE_SAVE;
    endproperty
    a_grant: assert property (p_grant) else $error("grant");
    property p_drop;
        RECLAIM |-> DROP_PKT && FIFO_ADVANCE && !STATE_SAVE;
    endproperty
    a_drop: assert property (p_drop) else $error("reclaim");
    property p_starve;
        ALLOC_REQ && ALLOC_STARVED && !ALLOC_GRANT
            |=> STATE_SAVE != RECLAIM && !SETUP_VALID;
    endproperty
    a_starve: assert property (p_starve) else $error("starve");
    property p_save;
        STATE_SAVE |-> !FIFO_ADVANCE && !DROP_PKT && !ALLOC_REQ;
    endproperty
    a_save: assert property (p_save) else $error("save");
    property p_retry;
        RETRY_START |-> ALLOC_REQ && !PKT_REQ_READY;
    endproperty
    a_retry: assert property (p_retry) else $error("retry");
    // Both outcomes are registered in the calc cycle, seen three edges on
    property p_take;
        PKT_REQ_VALID && PKT_REQ_READY
            |-> (##3 (DROP_PKT && !RECLAIM)) or (##3 ALLOC_REQ);
    endproperty
    a_take: assert property (p_take) else $error("take");
    property p_align;
        SETUP_VALID && SETUP.ps_loc_flag
            |-> SETUP.ps_addr[1:0] == 2'h0 && SETUP.fmt == 2'h0;
    endproperty
    a_align: assert property (p_align) else $error("align");
    property p_resv;
        AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS < 12'h800
            |-> AVS_READDATA[15:14] == 2'h0 && AVS_READDATA[31:29] == 3'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved");
endmodule

bind rfd_flow_setup rfd_flow_setup_monitor mon (
    .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .PKT_REQ_VALID(PKT_REQ_VALID),
    .PKT_REQ_READY(PKT_REQ_READY), .ALLOC_REQ(ALLOC_REQ),
    .ALLOC_GRANT(ALLOC_GRANT), .ALLOC_STARVED(ALLOC_STARVED),
    .SETUP_VALID(SETUP_VALID), .SETUP(SETUP), .DROP_PKT(DROP_PKT),
    .RECLAIM(RECLAIM), .STATE_SAVE(STATE_SAVE),
    .RETRY_START(RETRY_START), .FIFO_ADVANCE(FIFO_ADVANCE)
);

/* File: verif/rfd_flow_setup_tb_top.sv */
`timescale 1ns/1ps
module rfd_flow_setup_tb_top;
    logic clk, rst, rd, wr, pv, pr, areq, gnt, stv, starve, wreq;
    logic sv, drop, recl, save, retry, adv;
    logic [3:0] dly;
    logic [11:0] addr;
    logic [31:0] wdata, rdata, got;
    logic [1:0] resp, gresp;
    rfd_pkg::rfd_pkt_req_t preq;
    rfd_pkg::rfd_setup_t setup, su;
    int miscompares, n_tests, cyc, csave, cretry;
    int c[7];

    rfd_flow_setup dut (
        .CORE_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(addr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
        .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
        .AVS_RESPONSE(resp), .AVS_WAITREQUEST(wreq),
        .PKT_REQ_VALID(pv), .PKT_REQ(preq), .PKT_REQ_READY(pr),
        .ALLOC_REQ(areq), .ALLOC_GRANT(gnt), .ALLOC_STARVED(stv),
        .SETUP_VALID(sv), .SETUP(setup), .DROP_PKT(drop),
        .RECLAIM(recl), .STATE_SAVE(save), .RETRY_START(retry),
        .FIFO_ADVANCE(adv)
    );
    rfd_alloc_model qm (
        .clk(clk), .rst(rst), .alloc_req(areq), .starve(starve),
        .delay(dly), .grant(gnt), .starved(stv)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic give_verdict();
        if (miscompares == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic bus(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wreq !== 1'b0);
        got = rdata;
        gresp = resp;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    // Sends one packet and tallies the pulses until it completes
    task automatic pkt(input logic [7:0] f, input logic [31:0] da, ba);
        c = '{default: 0};
        @(posedge clk);
        preq <= '{f, da, ba, 8'h03};
        pv <= 1'b1;
        do @(posedge clk); while (pr !== 1'b1);
        pv <= 1'b0;
        cyc = 0;
        do begin
            @(posedge clk);
            cyc++;
            c[0] += sv === 1'b1;
            c[1] += drop === 1'b1;
            c[2] += recl === 1'b1;
            c[3] += save === 1'b1;
            c[4] += retry === 1'b1;
            c[5] += adv === 1'b1;
            c[6] += areq === 1'b1;
            if (save === 1'b1) begin
                csave = cyc;
                starve <= 1'b0;
            end
            if (retry === 1'b1) cretry = cyc;
            if (sv === 1'b1) su = setup;
        end while (sv !== 1'b1 && drop !== 1'b1);
    endtask

    task automatic t_regs();
        bus(1'b0, 12'h800, 32'h0);
        check(got, 32'h40);
        bus(1'b1, 12'h020, 32'hffffffff);
        bus(1'b0, 12'h020, 32'h0);
        check(got, 32'h1fff3fff);
        bus(1'b0, 12'h004, 32'h0);
        check(gresp, 2'h3);
        check(got, 32'h0);
        bus(1'b1, 12'h800, 32'h3);
    endtask

    task automatic t_host();
        dly <= 4'h5;
        bus(1'b1, 12'h040, 32'h11ff2abc);
        pkt(8'h02, 32'h1000, 32'h2000);
        check(c[0] + c[3], 1);
        check(su.ps_loc_flag, 1'b0);
        check(su.ps_addr, 32'h1020);
        check(su.payload_addr, 32'h21ff);
        check(su.qmgr, 2'h2);
        check(su.qnum, 12'habc);
    endtask

    task automatic t_inbuf();
        dly <= 4'h0;
        bus(1'b1, 12'h080, 32'h02061005);
        // Unaligned on purpose, shows the rounding
        pkt(8'h04, 32'h1000, 32'h2001);
        check(su.ps_loc_flag, 1'b1);
        check(su.ps_addr, 32'h2008);
        check(su.payload_addr, 32'h2014);
        // Pointer plus skip kept aligned
        pkt(8'h04, 32'h1000, 32'h2002);
        check(su.ps_addr, 32'h2008);
        check(su.payload_addr, 32'h2014);
    endtask

    task automatic t_mono();
        // Skip 24: header 12 plus three words
        bus(1'b1, 12'h0a0, 32'h08180007);
        pkt(8'h05, 32'h3000, 32'h0);
        check(su.fmt, 2'h2);
        check(su.payload_addr, 32'h3018);
    endtask

    task automatic t_drop();
        starve <= 1'b1;
        bus(1'b1, 12'h0c0, 32'h00000001);
        pkt(8'h06, 32'h1000, 32'h2000);
        check(c[1] + c[2] + c[5], 3);
        check(c[0] + c[3], 0);
    endtask

    task automatic t_retry();
        starve <= 1'b1;
        bus(1'b1, 12'h0e0, 32'h10000002);
        pkt(8'h07, 32'h1000, 32'h2000);
        check(c[3] + c[5], 2);
        check(c[0] + c[4], 2);
        check(cretry - csave, 3);
    endtask

    task automatic t_badfmt();
        for (int i = 1; i < 4; i += 2) begin
            bus(1'b1, 12'h100, 32'(i) << 26);
            pkt(8'h08, 32'h1000, 32'h2000);
            check(c[1] + c[2] + c[6], 1);
        end
        // One retry, one starvation drop, two format drops, idle
        bus(1'b0, 12'h804, 32'h0);
        check(got, 32'h01010200);
    endtask

    initial begin
        {rd, wr, pv, starve} = 4'h0;
        rst = 1'b1;
        dly = 4'h0;
        addr = 12'h0;
        wdata = 32'h0;
        preq = '0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // Flow words rewritten only between packets
        t_regs();
        t_host();
        t_inbuf();
        t_mono();
        t_drop();
        t_retry();
        t_badfmt();
        give_verdict();
    end

    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        give_verdict();
    end
endmodule
